// File: rtl/eprom_programmer.sv
/*
 Programmer that drives a UV EPROM through its pins: first pass of single
 pulses, verify/reprogram loop, final read-back compare, and an ID read.
 Assumes source data answers combinationally on src_data for src_addr, the
 EPROM data bus is resolved by the bench from data_oe, and supplies are
 switched by prog_supply_on (high during programming, low for read levels).
*/
//
// Functional notes
// - Program a word by one chip-select low pulse of 47.5 to 52.5 us.
// - Place the first array address before any program pulse.
// - First pass: one pulse per address, no verify read.
// - Then verify each word; on mismatch up to 10 more pulses, verify each.
// - Word still failing after 10 extra pulses: report whole part failed.
// - On verify, move to next address until all addresses checked.
// - At read levels, read every word again and compare; any mismatch fails.
// - Wait 150 ns after output-drive low before sampling; 130 ns float after release (after an ID read a program start can drive data 20 ns later).
// - ID mode: other address lines low, id line high, word-select picks code.
`default_nettype none
module eprom_programmer
	import prog_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W,
	parameter logic [AW-1:0] LAST_ADDR = {AW{1'b1}}
) (
	input  wire logic          sys_clk,
	input  wire logic          srst,
	input  wire logic          start_prog,
	input  wire logic          start_id,
	input  wire logic          id_sel,
	input  wire logic [DW-1:0] src_data,
	input  wire logic [DW-1:0] data_in,
	output logic      [AW-1:0] src_addr,
	output logic      [AW-1:0] addr,
	output logic               id_mode_address_line,
	output logic               chip_select_n,
	output logic               output_drive_n,
	output logic      [DW-1:0] data_out,
	output logic               data_oe,
	output logic               prog_supply_on,
	output logic               busy,
	output logic               done,
	output logic               pass,
	output logic               fail,
	output logic      [DW-1:0] id_word
);
	typedef enum logic [8:0] {
		ST_IDLE   = 9'h001,
		ST_SETUP  = 9'h002,
		ST_PULSE  = 9'h004,
		ST_HOLD   = 9'h008,
		ST_OEWAIT = 9'h010,
		ST_FLOAT  = 9'h020,
		ST_RDWAIT = 9'h040,
		ST_IDWAIT = 9'h080,
		ST_END    = 9'h100
	} state_e;

	typedef enum logic [1:0] {
		PH_FIRST  = 2'h0,
		PH_VERIFY = 2'h1,
		PH_FINAL  = 2'h2,
		PH_ID     = 2'h3
	} phase_e;

	state_e          state;
	state_e          next_state;
	phase_e          phase;
	phase_e          next_phase;
	logic [3:0]      retries;
	logic [3:0]      next_retries;
	logic            match_ok;
	logic            next_match_ok;
	logic [AW-1:0]   next_addr;
	logic            next_cs_n;
	logic            next_oe_n;
	logic            next_data_oe;
	logic            next_supply;
	logic            next_id_line;
	logic            next_done;
	logic            next_pass;
	logic            next_fail;
	logic [DW-1:0]   next_id_word;
	logic [DW-1:0]   next_data_out;
	logic            tmr_load;
	logic [TIMER_W-1:0] tmr_count;
	logic            tmr_done;
	logic            tmr_busy;
	logic            is_last;

	pulse_timer #(.WIDTH(TIMER_W)) u_timer (
		.sys_clk (sys_clk),
		.srst    (srst),
		.load    (tmr_load),
		.count   (tmr_count),
		.busy    (tmr_busy),
		.done    (tmr_done)
	);

	assign is_last = (addr == LAST_ADDR);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state    = state;
		next_phase    = phase;
		next_retries  = retries;
		next_match_ok = match_ok;
		next_addr     = addr;
		next_cs_n     = chip_select_n;
		next_oe_n     = output_drive_n;
		next_data_oe  = data_oe;
		next_supply   = prog_supply_on;
		next_id_line  = id_mode_address_line;
		next_done     = 1'b0;
		next_pass     = pass;
		next_fail     = fail;
		next_id_word  = id_word;
		next_data_out = data_out;
		tmr_load      = 1'b0;
		tmr_count     = '0;
		case (state)
			ST_IDLE: begin
				if (start_prog) begin
					// Address zero is set before the first pulse
					next_addr     = '0;
					next_phase    = PH_FIRST;
					next_supply   = 1'b1;
					next_oe_n     = 1'b1;
					next_data_oe  = 1'b1;
					next_data_out = src_data;
					next_pass     = 1'b0;
					next_fail     = 1'b0;
					next_retries  = '0;
					next_state    = ST_SETUP;
					tmr_load      = 1'b1;
					tmr_count     = TIMER_W'(SETUP_CYCLES);
				end else if (start_id) begin
					// All address lines low but word select, id line high
					next_addr     = {{(AW-1){1'b0}}, id_sel};
					next_id_line  = 1'b1;
					next_phase    = PH_ID;
					next_supply   = 1'b0;
					next_data_oe  = 1'b0;
					next_state    = ST_IDWAIT;
					tmr_load      = 1'b1;
					tmr_count     = TIMER_W'(SETUP_CYCLES);
				end
			end
			ST_SETUP: begin
				// Source word is only valid once src_addr has caught up with addr
				next_data_out = src_data;
				if (tmr_done) begin
					// Drive line held high, data driven while pulsing
					next_cs_n  = 1'b0;
					next_state = ST_PULSE;
					tmr_load   = 1'b1;
					tmr_count  = TIMER_W'(PULSE_CYCLES);
				end
			end
			ST_PULSE: begin
				if (tmr_done) begin
					// Pulse of PULSE_CYCLES plus one cycle lies inside the legal window
					next_cs_n  = 1'b1;
					next_state = ST_HOLD;
					tmr_load   = 1'b1;
					tmr_count  = TIMER_W'(SETUP_CYCLES);
				end
			end
			ST_HOLD: begin
				if (tmr_done) begin
					if (phase == PH_FIRST) begin
						// No verify read in the first pass
						if (is_last) begin
							next_phase = PH_VERIFY;
							next_addr  = '0;
						end else begin
							next_addr  = addr + 1'b1;
						end
						if (is_last) begin
							next_data_oe = 1'b0;
							next_oe_n    = 1'b0;
							next_state   = ST_OEWAIT;
							tmr_load     = 1'b1;
							tmr_count    = TIMER_W'(OE_WAIT_CYCLES);
						end else begin
							next_data_out = src_data;
							next_state    = ST_SETUP;
							tmr_load      = 1'b1;
							tmr_count     = TIMER_W'(SETUP_CYCLES);
						end
					end else begin
						// Release data then sample after the drive delay
						next_data_oe = 1'b0;
						next_oe_n    = 1'b0;
						next_state   = ST_OEWAIT;
						tmr_load     = 1'b1;
						tmr_count    = TIMER_W'(OE_WAIT_CYCLES);
					end
				end
			end
			ST_OEWAIT: begin
				if (tmr_done) begin
					// Sample only after the 150 ns data-valid time
					next_match_ok = (data_in == src_data);
					next_oe_n     = 1'b1;
					next_state    = ST_FLOAT;
					tmr_load      = 1'b1;
					tmr_count     = TIMER_W'(FLOAT_WAIT_CYCLES);
				end
			end
			ST_FLOAT: begin
				// Bus not driven again until outputs have floated
				if (tmr_done) begin
					if (phase == PH_FINAL) begin
						if (!match_ok) begin
							next_fail  = 1'b1;
							next_state = ST_END;
						end else if (is_last) begin
							next_pass  = 1'b1;
							next_state = ST_END;
						end else begin
							next_addr  = addr + 1'b1;
							next_oe_n  = 1'b0;
							next_state = ST_OEWAIT;
							tmr_load   = 1'b1;
							tmr_count  = TIMER_W'(OE_WAIT_CYCLES);
						end
					end else if (match_ok) begin
						// Verified word advances
						next_retries = '0;
						if (is_last) begin
							// Back to read levels then full compare
							next_supply = 1'b0;
							next_phase  = PH_FINAL;
							next_addr   = '0;
							next_state  = ST_RDWAIT;
							tmr_load    = 1'b1;
							tmr_count   = TIMER_W'(SETUP_CYCLES);
						end else begin
							next_addr  = addr + 1'b1;
							next_oe_n  = 1'b0;
							next_state = ST_OEWAIT;
							tmr_load   = 1'b1;
							tmr_count  = TIMER_W'(OE_WAIT_CYCLES);
						end
					end else if (retries == 4'(MAX_RETRY_PULSES)) begin
						// Ten extra pulses spent: whole part fails
						next_fail  = 1'b1;
						next_state = ST_END;
					end else begin
						// Another pulse then verify again
						next_retries  = retries + 1'b1;
						next_data_oe  = 1'b1;
						next_data_out = src_data;
						next_state    = ST_SETUP;
						tmr_load      = 1'b1;
						tmr_count     = TIMER_W'(SETUP_CYCLES);
					end
				end
			end
			ST_RDWAIT: begin
				if (tmr_done) begin
					next_oe_n  = 1'b0;
					next_state = ST_OEWAIT;
					tmr_load   = 1'b1;
					tmr_count  = TIMER_W'(OE_WAIT_CYCLES);
				end
			end
			ST_IDWAIT: begin
				if (tmr_done && !output_drive_n) begin
					next_id_word = data_in;
					next_oe_n    = 1'b1;
					next_id_line = 1'b0;
					next_state   = ST_END;
				end else if (tmr_done) begin
					next_cs_n  = 1'b0;
					next_oe_n  = 1'b0;
					tmr_load   = 1'b1;
					tmr_count  = TIMER_W'(OE_WAIT_CYCLES);
				end
			end
			ST_END: begin
				next_cs_n    = 1'b1;
				next_oe_n    = 1'b1;
				next_data_oe = 1'b0;
				next_supply  = 1'b0;
				next_done    = 1'b1;
				next_state   = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state                <= ST_IDLE;
			phase                <= PH_FIRST;
			retries              <= '0;
			match_ok             <= 1'b0;
			addr                 <= '0;
			chip_select_n        <= 1'b1;
			output_drive_n       <= 1'b1;
			data_oe              <= 1'b0;
			data_out             <= '0;
			prog_supply_on       <= 1'b0;
			id_mode_address_line <= 1'b0;
			done                 <= 1'b0;
			pass                 <= 1'b0;
			fail                 <= 1'b0;
			id_word              <= '0;
			busy                 <= 1'b0;
			src_addr             <= '0;
		end else begin
			state                <= next_state;
			phase                <= next_phase;
			retries              <= next_retries;
			match_ok             <= next_match_ok;
			addr                 <= next_addr;
			chip_select_n        <= next_cs_n;
			output_drive_n       <= next_oe_n;
			data_oe              <= next_data_oe;
			data_out             <= next_data_out;
			prog_supply_on       <= next_supply;
			id_mode_address_line <= next_id_line;
			done                 <= next_done;
			pass                 <= next_pass;
			fail                 <= next_fail;
			id_word              <= next_id_word;
			busy                 <= (next_state != ST_IDLE);
			src_addr             <= next_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	int unsigned low_len;
	always_ff @(posedge sys_clk) begin
		if (srst || chip_select_n) begin
			low_len <= 0;
		end else begin
			low_len <= low_len + 1;
		end
	end

	property p_pulse_min;
		@(posedge sys_clk) disable iff (srst)
		($rose(chip_select_n) && phase != PH_ID) |-> (low_len >= PULSE_MIN_CYCLES);
	endproperty
	a_pulse_min: assert property (p_pulse_min) else $error("pulse too short");

	property p_pulse_max;
		@(posedge sys_clk) disable iff (srst)
		(!chip_select_n && phase != PH_ID) |-> (low_len <= PULSE_MAX_CYCLES);
	endproperty
	a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");

	property p_prog_drive;
		@(posedge sys_clk) disable iff (srst)
		(!chip_select_n && phase != PH_ID) |-> (output_drive_n && data_oe);
	endproperty
	a_prog_drive: assert property (p_prog_drive) else $error("bad pin state in pulse");

	property p_no_contention;
		@(posedge sys_clk) disable iff (srst)
		!output_drive_n |-> !data_oe;
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("bus contention");

	property p_retry_bound;
		@(posedge sys_clk) disable iff (srst)
		retries <= 4'(MAX_RETRY_PULSES);
	endproperty
	a_retry_bound: assert property (p_retry_bound) else $error("too many retries");

	property p_first_no_read;
		@(posedge sys_clk) disable iff (srst)
		(phase == PH_FIRST && state != ST_IDLE && state != ST_END && state != ST_OEWAIT)
			|-> output_drive_n;
	endproperty
	a_first_no_read: assert property (p_first_no_read) else $error("read in first pass");

	property p_fail_excl;
		@(posedge sys_clk) disable iff (srst)
		!(pass && fail);
	endproperty
	a_fail_excl: assert property (p_fail_excl) else $error("pass and fail");

	property p_start_addr;
		@(posedge sys_clk) disable iff (srst)
		(state == ST_IDLE && start_prog) |=> (addr == '0 && chip_select_n);
	endproperty
	a_start_addr: assert property (p_start_addr) else $error("start address not zero");

	sequence s_drive_low;
		$fell(output_drive_n) && phase != PH_ID;
	endsequence
	property p_sample_wait;
		@(posedge sys_clk) disable iff (srst)
		s_drive_low |-> (!output_drive_n)[*8];
	endproperty
	a_sample_wait: assert property (p_sample_wait) else $error("sampled too early");

	property p_pulse_timed;
		@(posedge sys_clk) disable iff (srst)
		(state == ST_PULSE) |-> (tmr_busy || tmr_done);
	endproperty
	a_pulse_timed: assert property (p_pulse_timed) else $error("pulse not timed");
endmodule
`default_nettype wire

// File: rtl/prog_pkg.sv
/*
 Constants shared by the EPROM programming controller and its pulse timer.
 Assumes a 100 MHz system clock (10 ns period).
*/
`default_nettype none
package prog_pkg;
	localparam int CLK_PERIOD_NS        = 10;
	// Program pulse nominal 50 us, legal window 47.5 .. 52.5 us
	localparam int PULSE_NOM_NS         = 50000;
	localparam int PULSE_MIN_NS         = 47500;
	localparam int PULSE_MAX_NS         = 52500;
	localparam int PULSE_CYCLES         = PULSE_NOM_NS / CLK_PERIOD_NS;
	localparam int PULSE_MIN_CYCLES     = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_MAX_CYCLES     = PULSE_MAX_NS / CLK_PERIOD_NS;
	// Setup and hold around the pulse (address, data, output-drive): 2 us
	localparam int SETUP_NS             = 2000;
	localparam int SETUP_CYCLES         = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Read timing during verify
	localparam int DATA_VALID_AFTER_OUTPUT_DRIVE_NS = 150;
	localparam int OUTPUT_FLOAT_AFTER_RELEASE_NS    = 130;
	localparam int OE_WAIT_CYCLES       =
		(DATA_VALID_AFTER_OUTPUT_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOAT_WAIT_CYCLES    =
		(OUTPUT_FLOAT_AFTER_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MAX_RETRY_PULSES     = 10;
	localparam int TIMER_W              = 16;
	localparam int ADDR_W               = 19;
	localparam int DATA_W               = 16;
endpackage
`default_nettype wire

// File: rtl/pulse_timer.sv
/*
 Down-counting delay timer: load a cycle count, done pulses one cycle when it
 expires. Assumes sys_clk and synchronous srst.
*/
`default_nettype none
module pulse_timer
	import prog_pkg::*;
#(
	parameter int WIDTH = TIMER_W
) (
	input  wire logic             sys_clk,
	input  wire logic             srst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] count,
	output logic                  busy,
	output logic                  done
);
	logic [WIDTH-1:0] remain;
	logic [WIDTH-1:0] next_remain;
	logic             next_done;

	always_comb begin
		next_remain = remain;
		next_done   = 1'b0;
		if (load) begin
			next_remain = count;
		end else if (remain != '0) begin
			next_remain = remain - 1'b1;
			next_done   = (remain == {{(WIDTH-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			remain <= '0;
			done   <= 1'b0;
		end else begin
			remain <= next_remain;
			done   <= next_done;
		end
	end

	assign busy = (remain != '0);
endmodule
`default_nettype wire

// File: verification/eprom_model.sv
/*
 Pin-level model of the UV EPROM: two-word array, pulse programming with a
 per-word pulse need, verify reads, identification reads.
 Assumes the bench resolves the data bus and sets need and bad_addr per run.
*/
`default_nettype none
module eprom_model (
	input  wire logic        cs_n,
	input  wire logic        oe_n,
	input  wire logic        id_hi,
	input  wire logic        supply_on,
	input  wire logic        host_oe,
	input  wire logic        wipe,
	input  wire logic [18:0] addr,
	input  wire logic [15:0] din,
	output logic      [15:0] q,
	output logic             drv
);
	timeunit 1ns;
	timeprecision 1ps;
	parameter logic [15:0] MFR_ID = 16'h5A5A; // Arbitrary value
	parameter logic [15:0] DEV_ID = 16'h3C3C; // Arbitrary value
	// Just inside the 150 ns limit so the sample edge never races the data
	parameter int          T_DATA_VALID = 145;
	parameter int          T_DF   = 130;
	logic    [15:0] mem [2];
	int             need [2];
	int             pulses [2];
	int             viol;
	int             bad_addr;
	realtime        t_fall;
	////////////////////////////////////////////////////////////////////////
	initial begin
		q = 16'h0000;
		drv = 1'b0;
	end
	always @(posedge wipe) begin
		mem = '{16'hFFFF, 16'hFFFF};
		pulses = '{0, 0};
		viol = 0;
	end
	always @(negedge cs_n) begin
		t_fall = $realtime;
	end
	always @(posedge cs_n) if (supply_on === 1'b1) begin
		if ($realtime - t_fall < 47500.0 || $realtime - t_fall > 52500.0) viol++;
		if (pulses[0] + pulses[1] == 0 && addr != 0) viol++;
		if (oe_n !== 1'b1 || host_oe !== 1'b1 || addr[18:1] != 0) viol++;
		pulses[addr[0]]++;
		// Word only takes once it has had the pulses it needs
		if (pulses[addr[0]] >= need[addr[0]]) mem[addr[0]] = din;
	end
	////////////////////////////////////////////////////////////////////////
	always @(negedge oe_n) begin
		if (supply_on && (pulses[0] == 0 || pulses[1] == 0)) viol++;
		if (id_hi && addr[18:1] != 0) viol++;
		drv = 1'b1;
		q = ~q;
		#T_DATA_VALID;
		if (host_oe) viol++;
		if (!oe_n && id_hi) q = addr[0] ? DEV_ID : MFR_ID;
		else if (!oe_n) q = mem[addr[0]] ^ {15'h0000, !supply_on && bad_addr == addr[0]};
	end
	// Released bus shows the inverse of its last value, never a held copy
	always @(posedge oe_n) begin
		#T_DF;
		drv = 1'b0;
		q = ~q;
	end
	always @(posedge host_oe) if (drv) viol++;
endmodule
`default_nettype wire

// File: verification/eprom_program_verify_sequence_tb.sv
/*
 Self-checking bench for the EPROM programmer against the pin model.
 Assumes a two-word array (LAST_ADDR of 1) and source data from a table.
*/
`default_nettype none
module eprom_program_verify_sequence_tb;
	import prog_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		int   need0;
		int   need1;
		int   bad;
		logic ok;
		int   p0;
		int   p1;
	} row_s;
	logic        sys_clk, srst, start_prog, start_id, id_sel, wipe;
	logic        id_hi, cs_n, oe_n, data_oe, supply_on, busy, done, pass, fail, drv;
	logic [15:0] src_data, data_in, data_out, id_word, q;
	logic [18:0] src_addr, addr;
	logic [15:0] src_mem [2] = '{16'h1234, 16'hA5C3};
	int          num_errors = 0;
	int          n_compared = 0;
	// Boundary pass at ten retries, fail past ten, read-back fault
	row_s        rows [3] = '{'{11, 1, -1, 1'b1, 11, 1}, '{1, 12, -1, 1'b0, 1, 11},
		'{1, 1, 1, 1'b0, 1, 1}};
	assign src_data = src_mem[src_addr[0]];
	assign data_in  = data_oe ? data_out : q;
	////////////////////////////////////////////////////////////////////////
	eprom_programmer #(.LAST_ADDR(19'h00001)) eprom_programmer_i (
		.sys_clk(sys_clk), .srst(srst), .start_prog(start_prog), .start_id(start_id),
		.id_sel(id_sel), .src_data(src_data), .data_in(data_in), .src_addr(src_addr),
		.addr(addr), .id_mode_address_line(id_hi), .chip_select_n(cs_n),
		.output_drive_n(oe_n), .data_out(data_out), .data_oe(data_oe),
		.prog_supply_on(supply_on), .busy(busy), .done(done), .pass(pass), .fail(fail),
		.id_word(id_word));
	eprom_model eprom_model_i (
		.cs_n(cs_n), .oe_n(oe_n), .id_hi(id_hi), .supply_on(supply_on),
		.host_oe(data_oe), .wipe(wipe), .addr(addr), .din(data_out), .q(q), .drv(drv));
	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wait_done(input int lim);
		int i;
		for (i = 0; i < lim && done !== 1'b1; i++) @(negedge sys_clk);
		check({31'h0, done}, 32'h1);
	endtask
	task go(input logic prog);
		@(negedge sys_clk);
		start_prog = prog;
		start_id = !prog;
		@(negedge sys_clk);
		start_prog = 1'b0;
		start_id = 1'b0;
	endtask
	task stop_test;
		$display("errors=%0d compared=%0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Three runs of at most twelve pulses each need well under 3 ms
	initial begin
		#3_000_000;
		num_errors++;
		stop_test;
	end
	initial begin
		srst = 1'b1;
		start_prog = 1'b0;
		start_id = 1'b0;
		id_sel = 1'b0;
		wipe = 1'b0;
		repeat (12) @(negedge sys_clk);
		check({cs_n, oe_n, data_oe, busy, pass, fail, supply_on, id_hi}, 8'hC0);
		srst = 1'b0;
		foreach (rows[r]) begin
			eprom_model_i.need = '{rows[r].need0, rows[r].need1};
			eprom_model_i.bad_addr = rows[r].bad;
			wipe = 1'b1;
			@(negedge sys_clk);
			wipe = 1'b0;
			go(1'b1);
			wait_done(80000);
			check({pass, fail}, {rows[r].ok, !rows[r].ok});
			check(eprom_model_i.pulses[0], rows[r].p0);
			check(eprom_model_i.pulses[1], rows[r].p1);
			check(eprom_model_i.viol, 0);
			$display("program run %0d finished", r);
		end
		for (int s = 0; s < 2; s++) begin
			id_sel = s[0];
			go(1'b0);
			wait_done(1000);
			check(id_word, s ? 16'h3C3C : 16'h5A5A);
			check(eprom_model_i.viol, 0);
		end
		$display("identification reads finished");
		go(1'b1);
		repeat (50) @(negedge sys_clk);
		check({30'h0, busy, supply_on}, 32'h3);
		srst = 1'b1;
		@(negedge sys_clk);
		srst = 1'b0;
		check({cs_n, oe_n, data_oe, busy, supply_on, pass, fail}, 7'h60);
		$display("mid-run reset finished");
		stop_test;
	end
endmodule
`default_nettype wire
